// ### core/mcp_codec.sv
// Manchester line codec: encoder, decoder, collision translator, loopback.
// Assumes all pin inputs are asynchronous to CORE_CLK_I.
`timescale 1ns/100ps
`include "mcp_map.svh"

module mcp_codec
  import mcp_pkg::*;
(
  // Clock and reset
  input  wire logic CORE_CLK_I,
  input  wire logic RSTN_I,
  // Controller transmit side
  input  wire logic SEND_DATA_I,
  input  wire logic SEND_GATE_I,
  output logic      SEND_BIT_CLOCK_O,
  // Mode pins
  input  wire logic IDLE_SEL_I,
  input  wire logic LOOP_RETURN_ENABLE_I,
  // Controller receive side
  output logic      RECV_DATA_O,
  output logic      RECOVERED_BIT_CLOCK_O,
  output logic      CARRIER_PRESENT_O,
  output logic      CLASH_DETECT_O,
  // Line side
  input  wire logic RX_POS_I,
  input  wire logic RX_NEG_I,
  input  wire logic CLASH_IN_POS_I,
  input  wire logic CLASH_IN_NEG_I,
  output logic      TX_POS_O,
  output logic      TX_NEG_O
);

  logic [7:0]    sync1;
  logic [7:0]    sync2;
  logic          data_s, gate_s, sel_s, loop_s;
  logic          rx_s, col_s;
  // Encoder state
  mcp_tx_state_t state, next_state;
  logic [3:0]    tx_phase, next_tx_phase;
  logic [4:0]    hold_cnt, next_hold_cnt;
  logic          cur_bit, next_cur_bit;
  logic          tx_pos, next_tx_pos;
  logic          tx_neg, next_tx_neg;
  logic          tick, enc_lvl;
  // Decoder state
  logic          rx_prev, rx_lvl, rx_edge, mid;
  logic [6:0]    since, next_since;
  logic [3:0]    rx_phase, next_rx_phase;
  logic          carrier, next_carrier;
  logic          run, next_run;
  logic          rxd, next_rxd;
  // Collision state
  logic          col_prev, col_edge, col_good;
  logic [3:0]    gap, next_gap;
  logic [1:0]    good_cnt, next_good_cnt;
  logic          col, next_col;

  // Two stage synchroniser for every pin input
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      sync1 <= 8'h00;
      sync2 <= 8'h00;
    end else begin
      sync1 <= {SEND_DATA_I, SEND_GATE_I, IDLE_SEL_I, LOOP_RETURN_ENABLE_I,
                RX_POS_I, RX_NEG_I, CLASH_IN_POS_I, CLASH_IN_NEG_I};
      sync2 <= sync1;
    end
  end

  assign data_s = sync2[7];
  assign gate_s = sync2[6];
  assign sel_s  = sync2[5];
  assign loop_s = sync2[4];
  // Line inputs are ignored in loopback
  assign rx_s   = !loop_s && sync2[3] && !sync2[2];
  assign col_s  = !loop_s && sync2[1] && !sync2[0];
  // Encoder
  assign tick    = (tx_phase == 4'(`MCP_BIT_CYC - 1));
  assign enc_lvl = (state == MCP_SEND) ?
                   ((tx_phase < 4'(`MCP_HALF_CYC)) ? !cur_bit : cur_bit)
                   : 1'b1;
  always_comb begin
    next_state    = state;
    next_cur_bit  = cur_bit;
    next_hold_cnt = hold_cnt;
    next_tx_phase = tick ? 4'h0 : tx_phase + 4'h1;
    if (state == MCP_HOLD && hold_cnt != 5'h00) begin
      next_hold_cnt = hold_cnt - 5'h01;
    end
    case (state)
      MCP_IDLE: begin
        if (tick && gate_s) begin
          next_state   = MCP_SEND;
          next_cur_bit = data_s;
        end
      end
      MCP_SEND: begin
        if (tick && gate_s) begin
          next_cur_bit = data_s;
        end else if (tick) begin
          next_state    = MCP_HOLD;
          next_hold_cnt = 5'(`MCP_HOLD_HIGH_CYC - 1);
        end
      end
      MCP_HOLD: begin
        if (tick && gate_s) begin
          next_state   = MCP_SEND;
          next_cur_bit = data_s;
        end else if (hold_cnt == 5'h00) begin
          next_state = MCP_IDLE;
        end
      end
      default: begin
        next_state = MCP_IDLE;
      end
    endcase
    if (loop_s || next_state == MCP_IDLE) begin
      next_tx_pos = !sel_s;
      next_tx_neg = 1'b0;
    end else begin
      next_tx_pos = enc_lvl;
      next_tx_neg = !enc_lvl;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      state    <= MCP_IDLE;
      tx_phase <= 4'h0;
      hold_cnt <= 5'h00;
      cur_bit  <= 1'b0;
      tx_pos   <= 1'b0;
      tx_neg   <= 1'b0;
    end else begin
      state    <= next_state;
      tx_phase <= next_tx_phase;
      hold_cnt <= next_hold_cnt;
      cur_bit  <= next_cur_bit;
      tx_pos   <= next_tx_pos;
      tx_neg   <= next_tx_neg;
    end
  end

  // Decoder: an edge at least three quarters of a bit after the last
  // mid cell edge is the next mid cell edge; boundary edges are skipped
  assign rx_lvl  = loop_s ? enc_lvl : rx_s;
  assign rx_edge = rx_lvl ^ rx_prev;
  assign mid     = rx_edge &&
                   (!carrier || since >= 7'(`MCP_MID_GUARD_CYC));
  always_comb begin
    next_since    = (since == 7'h7F) ? since : since + 7'h01;
    next_rx_phase = (rx_phase == 4'(`MCP_BIT_CYC - 1)) ?
                    4'h0 : rx_phase + 4'h1;
    next_carrier  = carrier;
    next_run      = run;
    next_rxd      = rxd;
    if (mid) begin
      next_since    = 7'h00;
      next_rx_phase = 4'h0;
      next_carrier  = 1'b1;
      next_run      = 1'b1;
      next_rxd      = rx_lvl;
    end else begin
      if (since >= 7'(`MCP_CRS_HOLD_CYC)) begin
        next_carrier = 1'b0;
      end
      if (since >= 7'(`MCP_RXC_HOLD_CYC)) begin
        next_run = 1'b0;
      end
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rx_prev  <= 1'b0;
      since    <= 7'h7F;
      rx_phase <= 4'h0;
      carrier  <= 1'b0;
      run      <= 1'b0;
      rxd      <= 1'b0;
    end else begin
      rx_prev  <= rx_lvl;
      since    <= next_since;
      rx_phase <= next_rx_phase;
      carrier  <= next_carrier;
      run      <= next_run;
      rxd      <= next_rxd;
    end
  end

  // Collision translator: edges spaced as a 10 MHz half period
  assign col_edge = col_s ^ col_prev;
  assign col_good = col_edge &&
                    (gap >= 4'(`MCP_COL_MIN_CYC - 1)) &&
                    (gap <= 4'(`MCP_COL_MAX_CYC - 1));
  always_comb begin
    next_gap      = (gap == 4'hF) ? gap : gap + 4'h1;
    next_good_cnt = good_cnt;
    next_col      = col;
    if (col_edge) begin
      next_gap = 4'h0;
    end
    if (col_good) begin
      next_good_cnt = (good_cnt == 2'h3) ? good_cnt : good_cnt + 2'h1;
      if (good_cnt != 2'h0) begin
        next_col = 1'b1;
      end
    end else if (col_edge || gap >= 4'(`MCP_COL_MAX_CYC)) begin
      next_good_cnt = 2'h0;
      next_col      = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      col_prev <= 1'b0;
      gap      <= 4'hF;
      good_cnt <= 2'h0;
      col      <= 1'b0;
    end else begin
      col_prev <= col_s;
      gap      <= next_gap;
      good_cnt <= next_good_cnt;
      col      <= next_col;
    end
  end

  assign SEND_BIT_CLOCK_O      = (tx_phase < 4'(`MCP_HALF_CYC));
  assign TX_POS_O              = tx_pos;
  assign TX_NEG_O              = tx_neg;
  assign RECV_DATA_O           = rxd;
  // Rising edge lands mid way between two data updates
  assign RECOVERED_BIT_CLOCK_O = run &&
                                 (rx_phase >= 4'(`MCP_HALF_CYC));
  assign CARRIER_PRESENT_O     = carrier;
  assign CLASH_DETECT_O        = col;
  // Checks
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RSTN_I);
  sequence s_txc_low_half;
    !SEND_BIT_CLOCK_O [*5];
  endsequence
  a_txc_free_run: assert property ($fell(SEND_BIT_CLOCK_O) |->
    s_txc_low_half ##0 1'b1 ##1 SEND_BIT_CLOCK_O [*5] ##1 !SEND_BIT_CLOCK_O)
    else $error("transmit clock period wrong");
  a_idle_zero_diff: assert property (
    (RSTN_I && next_state == MCP_IDLE && sel_s) |=> (!TX_POS_O && !TX_NEG_O))
    else $error("half step idle not zero");
  a_idle_pos_high: assert property (
    (RSTN_I && next_state == MCP_IDLE && !sel_s) |=> (TX_POS_O && !TX_NEG_O))
    else $error("full step idle not positive");
  a_loop_drv_idle: assert property (loop_s |=>
    (TX_POS_O == !$past(sel_s)) && !TX_NEG_O)
    else $error("driver active in loopback");
  a_end_positive: assert property ((state == MCP_HOLD &&
    $past(state) == MCP_HOLD && !$past(loop_s)) |-> (TX_POS_O && !TX_NEG_O))
    else $error("frame did not end positive");
  a_send_sample: assert property ((tick && gate_s) |=>
    (state == MCP_SEND) && (cur_bit == $past(data_s)))
    else $error("transmit bit not sampled");
  a_enc_mid_edge: assert property ((state == MCP_SEND &&
    tx_phase == 4'h4) |=> (enc_lvl == cur_bit) && $changed(enc_lvl))
    else $error("no mid cell transition");
  a_crs_tracks: assert property (mid |=>
    CARRIER_PRESENT_O && (RECV_DATA_O == $past(rx_lvl)))
    else $error("carrier or data not updated");
  a_crs_drop: assert property ((since >= 7'h0F && !mid) |=>
    !CARRIER_PRESENT_O)
    else $error("carrier held too long");
  a_rxc_idle_low: assert property ((since >= 7'h41 && !mid) |=>
    !RECOVERED_BIT_CLOCK_O [*2])
    else $error("recovered clock not idle low");
  a_col_clear: assert property ((gap >= 4'h6 && !col_good) |=>
    !CLASH_DETECT_O)
    else $error("collision output stuck");
  a_col_set: assert property ((col_good && good_cnt != 2'h0) |=>
    CLASH_DETECT_O)
    else $error("collision not flagged");
endmodule : mcp_codec

// ### core/mcp_map.svh
// Timing constants of the line codec, expressed at the core clock rate.
// Assumes a 100 MHz core clock that stands in for the 20 MHz oscillator.
`ifndef MCP_MAP_SVH
`define MCP_MAP_SVH

`define MCP_CLK_NS        10
`define MCP_BIT_NS        100
`define MCP_BIT_CYC       (`MCP_BIT_NS / `MCP_CLK_NS)
`define MCP_HALF_CYC      (`MCP_BIT_CYC / 2)
`define MCP_MID_GUARD_CYC ((`MCP_BIT_CYC * 3) / 4)
`define MCP_CRS_HOLD_CYC  ((`MCP_BIT_CYC * 3) / 2)
`define MCP_RXC_BITS      5
`define MCP_RXC_HOLD_CYC  (`MCP_CRS_HOLD_CYC + `MCP_RXC_BITS * `MCP_BIT_CYC)
`define MCP_HOLD_HIGH_NS  200
`define MCP_HOLD_HIGH_CYC ((`MCP_HOLD_HIGH_NS + `MCP_CLK_NS - 1) / `MCP_CLK_NS)
`define MCP_COL_MIN_NS    40
`define MCP_COL_MIN_CYC   ((`MCP_COL_MIN_NS + `MCP_CLK_NS - 1) / `MCP_CLK_NS)
`define MCP_COL_MAX_NS    58
`define MCP_COL_MAX_CYC   (`MCP_COL_MAX_NS / `MCP_CLK_NS + 1)

`endif

// ### core/mcp_pkg.sv
// Types shared by the line codec.
// Assumes mcp_map.svh supplies the timing constants.
package mcp_pkg;

  typedef enum logic [2:0] {
    MCP_IDLE = 3'b001,
    MCP_SEND = 3'b010,
    MCP_HOLD = 3'b100
  } mcp_tx_state_t;

endpackage : mcp_pkg

// ### verification/mcp_mac_model.sv
// Controller side model: sends NRZ bytes, collects recovered bits.
// Assumes the codec core clock and the codec's two bit clocks.
`timescale 1ns/100ps

module mcp_mac_model (
  // Clock
  input  wire logic clk_i,
  // Codec outputs
  input  wire logic send_bit_clock_i,
  input  wire logic recv_data_i,
  input  wire logic recovered_bit_clock_i,
  // Codec inputs
  output logic      send_data_o,
  output logic      send_gate_o
);
  logic txc_q;
  logic rxc_q;
  logic rx_q[$];

  initial begin
    send_data_o = 1'b0;
    send_gate_o = 1'b0;
  end

  // Capture on the recovered clock rise
  always @(posedge clk_i) begin
    txc_q <= send_bit_clock_i;
    rxc_q <= recovered_bit_clock_i;
    if (recovered_bit_clock_i && rxc_q === 1'b0) begin
      rx_q.push_back(recv_data_i);
    end
  end

  // Byte goes out LSB first; levels change just after a clock rise
  task send_frame(input logic [7:0] data);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_i iff (send_bit_clock_i && txc_q === 1'b0));
      send_gate_o <= 1'b1;
      send_data_o <= data[i];
    end
    @(posedge clk_i iff (send_bit_clock_i && txc_q === 1'b0));
    send_gate_o <= 1'b0;
    send_data_o <= ~data[7];
  endtask : send_frame
endmodule : mcp_mac_model

// ### verification/mcp_codec_test.sv
// Self-checking bench for the line codec.
// Assumes mcp_mac_model stands in for the controller.
`timescale 1ns/100ps

module mcp_codec_test;
  logic core_clk = 1'b0;
  logic rstn     = 1'b0;
  logic idle_sel = 1'b0;
  logic loop_en  = 1'b0;
  logic rx_pos   = 1'b0;
  logic rx_neg   = 1'b0;
  logic cl_pos   = 1'b0;
  logic cl_neg   = 1'b0;
  logic send_data, send_gate, sbc, recv_data, recovered_bit_clock, carrier_present, col, tx_pos, tx_neg;
  logic prev;
  int   fails = 0;
  int   samples_checked = 0;
  int   cyc = 0;
  int   hi, rises;
  int   half[3] = '{5, 4, 10};
  logic col_exp[3] = '{1'b1, 1'b1, 1'b0};
  logic [7:0] rx_byte = 8'h5B;

  always #5 core_clk = ~core_clk;

  mcp_codec u_mcp_codec (
    .CORE_CLK_I(core_clk), .RSTN_I(rstn),
    .SEND_DATA_I(send_data), .SEND_GATE_I(send_gate),
    .SEND_BIT_CLOCK_O(sbc), .IDLE_SEL_I(idle_sel),
    .LOOP_RETURN_ENABLE_I(loop_en), .RECV_DATA_O(recv_data),
    .RECOVERED_BIT_CLOCK_O(recovered_bit_clock), .CARRIER_PRESENT_O(carrier_present),
    .CLASH_DETECT_O(col), .RX_POS_I(rx_pos), .RX_NEG_I(rx_neg),
    .CLASH_IN_POS_I(cl_pos), .CLASH_IN_NEG_I(cl_neg),
    .TX_POS_O(tx_pos), .TX_NEG_O(tx_neg));

  mcp_mac_model u_mcp_mac_model (
    .clk_i(core_clk), .send_bit_clock_i(sbc), .recv_data_i(recv_data),
    .recovered_bit_clock_i(recovered_bit_clock), .send_data_o(send_data),
    .send_gate_o(send_gate));

  task give_verdict;
    if (fails == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict

  task chk(input logic got, input logic exp, input string msg);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : chk

  task rx_half(input logic v);
    @(posedge core_clk);
    rx_pos <= v;
    rx_neg <= ~v;
    repeat (4) @(posedge core_clk);
  endtask : rx_half

  task clash(input int hp, input int n);
    for (int i = 0; i < n; i++) begin
      repeat (hp) @(posedge core_clk);
      cl_pos <= ~cl_pos;
      cl_neg <= cl_pos;
    end
    @(posedge core_clk);
    cl_pos <= 1'b0;
    cl_neg <= 1'b0;
  endtask : clash

  task rx_check(input logic [7:0] d);
    for (int i = 0; i < 8; i++) chk(u_mcp_mac_model.rx_q[i], d[i], "rx bit");
  endtask : rx_check

  task tx_frame(input logic sel, input logic [7:0] d);
    int k;
    @(posedge core_clk);
    idle_sel <= sel;
    repeat (20) @(negedge core_clk);
    chk(tx_pos, ~sel, "idle pos");
    chk(tx_neg, 1'b0, "idle neg");
    fork
      u_mcp_mac_model.send_frame(d);
      begin
        k = 0;
        while (tx_neg !== 1'b1 && k < 100) begin
          @(negedge core_clk);
          k++;
        end
        for (int i = 0; i < 8; i++) begin
          repeat (2) @(negedge core_clk);
          chk(tx_pos, ~d[i], "first half pos");
          chk(tx_neg, d[i], "first half neg");
          repeat (5) @(negedge core_clk);
          chk(tx_pos, d[i], "second half");
          repeat (3) @(negedge core_clk);
        end
        repeat (2) @(negedge core_clk);
        chk(tx_pos & ~tx_neg, 1'b1, "end positive");
        repeat (14) @(negedge core_clk);
        chk(tx_pos & ~tx_neg, 1'b1, "end hold");
        repeat (9) @(negedge core_clk);
        chk(tx_pos, ~sel, "idle after frame");
        chk(tx_neg, 1'b0, "idle neg after frame");
      end
    join
  endtask : tx_frame

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      give_verdict;
    end
  end

  initial begin
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (4) @(negedge core_clk);
    hi = 0;
    rises = 0;
    prev = sbc;
    repeat (40) begin
      @(negedge core_clk);
      hi += sbc;
      rises += (sbc & ~prev);
      prev = sbc;
    end
    chk(hi == 20, 1'b1, "send clock duty");
    chk(rises == 4, 1'b1, "send clock rate");
    tx_frame(1'b0, 8'h25);
    tx_frame(1'b1, 8'hA5);
    @(posedge core_clk);
    loop_en <= 1'b1;
    // A mode switch shows the decoder one false edge; let it go idle
    repeat (80) @(posedge core_clk);
    u_mcp_mac_model.rx_q.delete();
    fork
      u_mcp_mac_model.send_frame(8'hA6);
      clash(5, 24);
      repeat (110) begin
        @(negedge core_clk);
        chk(tx_pos | tx_neg, 1'b0, "loopback driver");
        chk(col, 1'b0, "loopback collision");
      end
    join
    repeat (20) @(negedge core_clk);
    rx_check(8'hA6);
    @(posedge core_clk);
    loop_en <= 1'b0;
    repeat (80) @(posedge core_clk);
    u_mcp_mac_model.rx_q.delete();
    for (int i = 0; i < 8; i++) begin
      rx_half(~rx_byte[i]);
      rx_half(rx_byte[i]);
    end
    @(posedge core_clk);
    rx_pos <= 1'b0;
    rx_neg <= 1'b0;
    repeat (7) @(negedge core_clk);
    chk(carrier_present, 1'b1, "carrier held");
    repeat (10) @(negedge core_clk);
    chk(carrier_present, 1'b0, "carrier dropped");
    rises = 0;
    prev = recovered_bit_clock;
    repeat (30) begin
      @(negedge core_clk);
      rises += (recovered_bit_clock & ~prev);
      prev = recovered_bit_clock;
    end
    chk(rises > 0, 1'b1, "rx clock after carrier");
    repeat (25) @(negedge core_clk);
    repeat (20) begin
      @(negedge core_clk);
      chk(recovered_bit_clock, 1'b0, "rx clock idle");
    end
    rx_check(rx_byte);
    for (int j = 0; j < 3; j++) begin
      fork
        clash(half[j], 16);
        begin
          repeat (50) @(negedge core_clk);
          chk(col, col_exp[j], "collision level");
        end
      join
      repeat (34) @(negedge core_clk);
      chk(col, 1'b0, "collision cleared");
    end
    give_verdict;
  end
endmodule : mcp_codec_test
